//--- pkg/rfc_cfg.svh
// Constants for the recovery-limit and feature-control command block
`ifndef RFC_CFG_SVH
`define RFC_CFG_SVH
// ****************************************************************
// Action, function, selection and feature codes
// ****************************************************************
`define RFC_ACT_ERC        16'h0003
`define RFC_ACT_FEAT       16'h0004
`define RFC_FN_SET         16'h0001
`define RFC_FN_GET         16'h0002
`define RFC_FN_FLAGS       16'h0003
`define RFC_SEL_READ       16'h0001
`define RFC_SEL_WRITE      16'h0002
`define RFC_FC_WCACHE      16'h0001
`define RFC_FC_REORDER     16'h0002
`define RFC_FC_TEMPLOG     16'h0003
`define RFC_WC_BY_SETF     16'h0001
`define RFC_WC_FORCE_ON    16'h0002
`define RFC_WC_FORCE_OFF   16'h0003
`define RFC_MIN_LIMIT      16'h0041
`define RFC_ESC_TIMEOUT    16'h0015
// ****************************************************************
// Task file answers
// ****************************************************************
`define RFC_ERR_OK         8'h00
`define RFC_ERR_ABRT       8'h04
`define RFC_ERR_UNC        8'h40
`define RFC_STAT_OK        8'h50
`define RFC_STAT_ERR       8'h51
// ****************************************************************
// Defaults and timing
// ****************************************************************
`define RFC_FEAT_DEFAULT   16'h0001
`define RFC_STEP_MS        100
`define RFC_CLK_MHZ        50
// ****************************************************************
// Register map (AXI4-Lite byte addresses)
// ****************************************************************
`define RFC_A_KEY0         12'h000
`define RFC_A_KEY1         12'h004
`define RFC_A_KEY2         12'h008
`define RFC_A_KEY3         12'h00c
`define RFC_A_KEY4         12'h010
`define RFC_A_ISSUE        12'h014
`define RFC_A_TFOUT        12'h018
`define RFC_A_LIMITS       12'h01c
`define RFC_A_FEAT         12'h020
`define RFC_A_ESC          12'h024
`define RFC_A_NVFEAT       12'h028
`define RFC_A_PRESET       12'h02c
`endif

//--- pkg/rfc_pkg.sv
// Types for the recovery-limit and feature-control command block
`default_nettype none
package rfc_pkg;
  typedef enum logic [1:0] {RFC_IDLE, RFC_RUN} rfc_state_t;
  typedef enum logic [1:0] {RFC_K_NONQ, RFC_K_NCQ_INORD, RFC_K_NCQ_OOO, RFC_K_STREAM} rfc_kind_t;
endpackage : rfc_pkg
`default_nettype wire

//--- hw/rfc_core.sv
// Recovery-limit and feature-control command interpreter with AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "rfc_cfg.svh"

module rfc_core
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_hard_reset,
  input  wire logic        i_cmd_start,
  input  wire logic        i_cmd_is_write,
  input  wire logic [1:0]  i_cmd_kind,
  input  wire logic        i_cmd_exec_start,
  input  wire logic        i_cmd_done,
  input  wire logic        i_cmd_reads_ncq_log,
  input  wire logic        i_setf_wcache,
  output logic             o_cmd_abort,
  output logic             o_cmd_uncorrectable,
  output logic             o_wcache_enable,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);

  localparam int STEP_CYC = `RFC_STEP_MS * 1000 * `RFC_CLK_MHZ;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] tf_word(input logic [7:0] err, input logic [7:0] stat, input logic [15:0] v);
    return {stat, err, v[15:8], v[7:0]};
  endfunction : tf_word

  // ****************************************************************
  // State
  // ****************************************************************
  logic [15:0] key [0:4];
  logic [31:0] tfout, next_tfout;
  logic [15:0] lim_rd, next_lim_rd, lim_wr, next_lim_wr;
  logic [15:0] feat [1:3];
  logic [15:0] nvf [1:3];
  logic [15:0] optf [1:3];
  logic [15:0] next_feat [1:3];
  logic [15:0] next_nvf [1:3];
  logic [15:0] next_optf [1:3];
  logic [15:0] esc, next_esc;
  rfc_pkg::rfc_state_t st, next_st;
  logic [15:0] lim, next_lim;
  logic [15:0] steps, next_steps;
  logic [22:0] pre, next_pre;
  logic        run_wr, next_run_wr;
  logic        abort_q, next_abort_q, unc_q, next_unc_q;
  logic        hr_m, hr_s;
  logic        aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [11:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic [3:0]  ws_q, next_ws_q;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        issue;
  logic        wr_go;

  // Hard reset comes from the link side: two flops before use
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      hr_m <= 1'b0;
      hr_s <= 1'b0;
    end
    else
    begin
      hr_m <= i_hard_reset;
      hr_s <= hr_m;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign o_awready = !aw_hold && !bvalid;
  assign o_wready  = !w_hold && !bvalid;
  assign o_arready = !rvalid;
  assign wr_go     = (aw_hold || i_awvalid) && (w_hold || i_wvalid) && !bvalid;
  assign o_bvalid  = bvalid;
  assign o_bresp   = bresp;
  assign o_rvalid  = rvalid;
  assign o_rresp   = rresp;
  assign o_rdata   = rdata;

  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0]  wsb;
  logic [31:0] key_m;
  always_comb
  begin
    wa  = aw_hold ? aw_q : i_awaddr;
    wd  = w_hold ? w_q : i_wdata;
    wsb = w_hold ? ws_q : i_wstrb;
    // Index clamped so an unmapped address never reads past the key words
    key_m = merge({16'h0000, key[(wa[4:2] > 3'h4) ? 3'h4 : wa[4:2]]}, wd, wsb);
    issue = wr_go && wa == `RFC_A_ISSUE && wsb[0] && wd[0];
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_q = aw_q;
    next_w_q  = w_q;
    next_ws_q = ws_q;
    next_bvalid = bvalid && !i_bready;
    next_bresp  = bresp;
    if (i_awvalid && o_awready && !wr_go)
    begin
      next_aw_hold = 1'b1;
      next_aw_q = i_awaddr;
    end
    if (i_wvalid && o_wready && !wr_go)
    begin
      next_w_hold = 1'b1;
      next_w_q  = i_wdata;
      next_ws_q = i_wstrb;
    end
    if (wr_go)
    begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wa[1:0] == 2'h0 && (wa <= `RFC_A_ISSUE || wa == `RFC_A_PRESET)) ? 2'h0 : 2'h2;
    end
    next_rvalid = rvalid && !i_rready;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (i_arvalid && o_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = 2'h0;
      unique case (i_araddr)
        `RFC_A_KEY0:   next_rdata = {16'h0000, key[0]};
        `RFC_A_KEY1:   next_rdata = {16'h0000, key[1]};
        `RFC_A_KEY2:   next_rdata = {16'h0000, key[2]};
        `RFC_A_KEY3:   next_rdata = {16'h0000, key[3]};
        `RFC_A_KEY4:   next_rdata = {16'h0000, key[4]};
        `RFC_A_ISSUE:  next_rdata = 32'h0000_0000;
        `RFC_A_TFOUT:  next_rdata = tfout;
        `RFC_A_LIMITS: next_rdata = {lim_wr, lim_rd};
        `RFC_A_FEAT:   next_rdata = {13'h0000, o_wcache_enable, st == rfc_pkg::RFC_RUN, run_wr, feat[1]};
        `RFC_A_ESC:    next_rdata = {16'h0000, esc};
        `RFC_A_NVFEAT: next_rdata = {nvf[2], nvf[1]};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'h2;
        end
      endcase
    end
  end

  // ****************************************************************
  // Key-sector command execution and recovery timers
  // ****************************************************************
  logic [15:0] k_act, k_fn, k_sel, k_val, k_opt;
  logic        fc_ok;
  logic        timed;
  always_comb
  begin
    k_act = key[0];
    k_fn  = key[1];
    k_sel = key[2];
    k_val = key[3];
    k_opt = key[4];
    fc_ok = k_sel == `RFC_FC_WCACHE || k_sel == `RFC_FC_REORDER || k_sel == `RFC_FC_TEMPLOG;
    next_tfout  = tfout;
    next_lim_rd = lim_rd;
    next_lim_wr = lim_wr;
    next_feat = feat;
    next_nvf  = nvf;
    next_optf = optf;
    next_esc  = esc;
    if (issue)
    begin
      next_tfout = tf_word(`RFC_ERR_ABRT, `RFC_STAT_ERR, 16'h0000);
      if (k_act == `RFC_ACT_ERC && (k_sel == `RFC_SEL_READ || k_sel == `RFC_SEL_WRITE))
      begin
        if (k_fn == `RFC_FN_SET && k_val >= `RFC_MIN_LIMIT)
        begin
          if (k_sel == `RFC_SEL_READ)
            next_lim_rd = k_val;
          else
            next_lim_wr = k_val;
          next_tfout = tf_word(`RFC_ERR_OK, `RFC_STAT_OK, 16'h0000);
        end
        else if (k_fn == `RFC_FN_GET)
        begin
          next_tfout = tf_word(`RFC_ERR_OK, `RFC_STAT_OK, k_sel == `RFC_SEL_READ ? lim_rd : lim_wr);
        end
      end
      else if (k_act == `RFC_ACT_FEAT && fc_ok)
      begin
        if (k_fn == `RFC_FN_SET)
        begin
          next_feat[k_sel[1:0]] = k_val;
          next_optf[k_sel[1:0]] = {15'h0000, k_opt[0]};
          if (k_opt[0])
            next_nvf[k_sel[1:0]] = k_val;
          next_tfout = tf_word(`RFC_ERR_OK, `RFC_STAT_OK, 16'h0000);
        end
        else if (k_fn == `RFC_FN_GET)
          next_tfout = tf_word(`RFC_ERR_OK, `RFC_STAT_OK, feat[k_sel[1:0]]);
        else if (k_fn == `RFC_FN_FLAGS)
          next_tfout = tf_word(`RFC_ERR_OK, `RFC_STAT_OK, optf[k_sel[1:0]]);
      end
    end
    if (hr_s)
    begin
      next_lim_rd = 16'h0000;
      next_lim_wr = 16'h0000;
      next_feat = nvf;
    end
    // Command start clears the status unless the command reads the NCQ log; the timeout set below wins
    if (i_cmd_start && !i_cmd_reads_ncq_log)
      next_esc = 16'h0000;
    next_st = st;
    next_lim = lim;
    next_steps = steps;
    next_pre = pre;
    next_run_wr = run_wr;
    next_abort_q = 1'b0;
    next_unc_q = 1'b0;
    timed = i_cmd_kind == rfc_pkg::RFC_K_NONQ || i_cmd_kind == rfc_pkg::RFC_K_NCQ_INORD;
    unique case (st)
      rfc_pkg::RFC_IDLE:
      begin
        // Non-queued: from arrival; in-order queued: from execution start
        if (((i_cmd_start && i_cmd_kind == rfc_pkg::RFC_K_NONQ) ||
             (i_cmd_exec_start && i_cmd_kind == rfc_pkg::RFC_K_NCQ_INORD)) && timed &&
            (i_cmd_is_write ? lim_wr : lim_rd) != 16'h0000 && !i_cmd_done)
        begin
          next_st = rfc_pkg::RFC_RUN;
          next_lim = i_cmd_is_write ? lim_wr : lim_rd;
          next_run_wr = i_cmd_is_write;
          next_steps = 16'h0000;
          next_pre = 23'h000000;
        end
      end
      rfc_pkg::RFC_RUN:
      begin
        if (i_cmd_done || hr_s)
          next_st = rfc_pkg::RFC_IDLE;
        else if (pre == 23'(STEP_CYC - 1))
        begin
          next_pre = 23'h000000;
          next_steps = steps + 16'h0001;
          if (steps + 16'h0001 == lim)
          begin
            next_st = rfc_pkg::RFC_IDLE;
            next_abort_q = run_wr;
            next_unc_q = !run_wr;
            next_esc = `RFC_ESC_TIMEOUT;
          end
        end
        else
          next_pre = pre + 23'h000001;
      end
    endcase
  end

  // Write cache follows set-features unless forced
  always_comb
  begin
    unique case (feat[1])
      `RFC_WC_FORCE_ON:  o_wcache_enable = 1'b1;
      `RFC_WC_FORCE_OFF: o_wcache_enable = 1'b0;
      default:           o_wcache_enable = i_setf_wcache;
    endcase
  end
  assign o_cmd_abort = abort_q;
  assign o_cmd_uncorrectable = unc_q;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < 5; i++)
        key[i] <= 16'h0000;
      for (int i = 1; i < 4; i++)
      begin
        feat[i] <= `RFC_FEAT_DEFAULT;
        nvf[i]  <= `RFC_FEAT_DEFAULT;
        optf[i] <= 16'h0000;
      end
      tfout <= 32'h0000_0000;
      lim_rd <= 16'h0000;
      lim_wr <= 16'h0000;
      esc <= 16'h0000;
      st <= rfc_pkg::RFC_IDLE;
      lim <= 16'h0000;
      steps <= 16'h0000;
      pre <= 23'h000000;
      run_wr <= 1'b0;
      abort_q <= 1'b0;
      unc_q <= 1'b0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_go && wa[1:0] == 2'h0 && wa <= `RFC_A_KEY4)
        key[wa[4:2]] <= key_m[15:0];
      if (wr_go && wa == `RFC_A_PRESET && wsb[0] && wd[0])
      begin
        // Power-up preset: models a power cycle of the non-volatile copy
        for (int i = 1; i < 4; i++)
          nvf[i] <= `RFC_FEAT_DEFAULT;
      end
      else
        nvf <= next_nvf;
      feat <= next_feat;
      optf <= next_optf;
      tfout <= next_tfout;
      lim_rd <= next_lim_rd;
      lim_wr <= next_lim_wr;
      esc <= next_esc;
      st <= next_st;
      lim <= next_lim;
      steps <= next_steps;
      pre <= next_pre;
      run_wr <= next_run_wr;
      abort_q <= next_abort_q;
      unc_q <= next_unc_q;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      ws_q <= next_ws_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

endmodule : rfc_core
`default_nettype wire

//--- verif/rfc_core_assertions.sv
// Port-level checks for the command block
`timescale 1ns/10ps
`default_nettype none
module rfc_core_assertions
(
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic        i_arvalid,
  input wire logic        i_bready,
  input wire logic        i_rready,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        o_cmd_abort,
  input wire logic        o_cmd_uncorrectable
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  chk_b_blocks_req: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write channels open while response pending");
  chk_b_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response changed before taken");
  chk_b_release: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response not released");
  chk_r_blocks_ar: assert property (o_rvalid |-> !o_arready)
    else $error("read address open while data pending");
  chk_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed before taken");
  chk_r_release: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read data not released");
  chk_fault_excl: assert property (o_cmd_abort |-> !o_cmd_uncorrectable)
    else $error("abort and uncorrectable together");
  chk_abort_pulse: assert property (o_cmd_abort |=> !o_cmd_abort)
    else $error("abort longer than one cycle");
  chk_unc_pulse: assert property (o_cmd_uncorrectable |=> !o_cmd_uncorrectable)
    else $error("uncorrectable longer than one cycle");
  chk_reset_quiet: assert property ($rose(i_rstn) |-> !o_cmd_abort && !o_cmd_uncorrectable)
    else $error("timeout reported out of reset");
endmodule : rfc_core_assertions
bind rfc_core rfc_core_assertions chk_i (.i_clock, .i_rstn, .i_arvalid, .i_bready, .i_rready, .o_awready,
  .o_wready, .o_bvalid, .o_bresp, .o_arready, .o_rvalid, .o_rdata, .o_cmd_abort, .o_cmd_uncorrectable);
`default_nettype wire

//--- verif/rfc_host_model.sv
// Host command source stepping ordinary commands through issue, execution and completion
`timescale 1ns/10ps
`default_nettype none
module rfc_host_model
(
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_step,
  input  wire logic       i_write,
  input  wire logic       i_log,
  input  wire logic [1:0] i_kind,
  output logic            o_cmd_start,
  output logic            o_cmd_is_write,
  output logic [1:0]      o_cmd_kind,
  output logic            o_cmd_exec_start,
  output logic            o_cmd_done,
  output logic            o_cmd_reads_ncq_log
);
  logic [1:0] phase;
  // Qualifiers latched at issue and held to completion; steps let the bench pace it fast or slow
  always_ff @(posedge i_clock)
  begin
    o_cmd_start      <= 1'b0;
    o_cmd_exec_start <= 1'b0;
    o_cmd_done       <= 1'b0;
    if (!i_rstn)
    begin
      phase               <= 2'd0;
      o_cmd_is_write      <= 1'b0;
      o_cmd_kind          <= 2'd0;
      o_cmd_reads_ncq_log <= 1'b0;
    end
    else if (i_step)
    begin
      phase <= (phase == 2'd2) ? 2'd0 : phase + 2'd1;
      if (phase == 2'd0)
      begin
        o_cmd_start         <= 1'b1;
        o_cmd_is_write      <= i_write;
        o_cmd_kind          <= i_kind;
        o_cmd_reads_ncq_log <= i_log;
      end
      o_cmd_exec_start <= (phase == 2'd1) && (o_cmd_kind == 2'd1 || o_cmd_kind == 2'd2);
      o_cmd_done       <= (phase == 2'd2);
    end
  end
endmodule : rfc_host_model
`default_nettype wire

//--- verif/test_sct_recovery_feature_cmds.sv
// Self-checking bench for the recovery-limit and feature-control block
`timescale 1ns/10ps
`default_nettype none
`include "rfc_cfg.svh"
module test_sct_recovery_feature_cmds;
  logic        i_clock, i_rstn, i_hard_reset, i_setf_wcache, step, wr_sel, log_sel;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [1:0]  kind_sel, rsp;
  logic [3:0]  i_wstrb;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, d, seed;
  logic [15:0] lim;
  logic        fault_seen = 1'b0;
  logic [15:0] bad [4][5];
  wire         i_cmd_start, i_cmd_is_write, i_cmd_exec_start, i_cmd_done, i_cmd_reads_ncq_log;
  wire         o_cmd_abort, o_cmd_uncorrectable, o_wcache_enable, o_awready, o_wready, o_bvalid;
  wire         o_arready, o_rvalid;
  wire [1:0]   i_cmd_kind, o_bresp, o_rresp;
  wire [31:0]  o_rdata;
  int          error_cnt, checks_done, cycles;
  rfc_host_model host (.i_clock, .i_rstn, .i_step(step), .i_write(wr_sel), .i_log(log_sel), .i_kind(kind_sel),
    .o_cmd_start(i_cmd_start), .o_cmd_is_write(i_cmd_is_write), .o_cmd_kind(i_cmd_kind),
    .o_cmd_exec_start(i_cmd_exec_start), .o_cmd_done(i_cmd_done), .o_cmd_reads_ncq_log(i_cmd_reads_ncq_log));
  rfc_core uut (.i_clock, .i_rstn, .i_hard_reset, .i_cmd_start, .i_cmd_is_write, .i_cmd_kind, .i_cmd_exec_start,
    .i_cmd_done, .i_cmd_reads_ncq_log, .i_setf_wcache, .o_cmd_abort, .o_cmd_uncorrectable, .o_wcache_enable,
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
  // ********
  // Helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] tf_ok(input logic [15:0] v);
    tf_ok = {8'h50, 8'h00, v};
  endfunction : tf_ok
  task automatic report_and_stop;
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge i_clock);
      if (i_awvalid && o_awready) aw_ok = 1'b1;
      if (i_wvalid && o_wready) w_ok = 1'b1;
      if (aw_ok) i_awvalid <= 1'b0;
      if (w_ok) i_wvalid <= 1'b0;
    end
    do @(posedge i_clock); while (!o_bvalid);
    chk({30'h0, o_bresp}, {30'h0, er});
    i_bready <= 1'b0;
    @(posedge i_clock);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clock); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clock); while (!o_rvalid);
    v = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
    @(posedge i_clock);
  endtask : rd
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask : rdm
  task automatic key(input logic [15:0] k [5], input logic [31:0] exp, input logic full);
    logic [31:0] v;
    for (int n = 0; n < 5; n++)
      wr(12'(4 * n), {16'h0000, k[n]}, 2'b00);  // Reserved halves sent as zero
    wr(`RFC_A_ISSUE, 32'h00000001, 2'b00);
    rd(`RFC_A_TFOUT, v);
    if (full) chk(v, exp);
    else chk({16'h0, v[31:16]}, {16'h0, exp[31:16]});
  endtask : key
  task automatic step_cmd;
    step <= 1'b1;
    @(posedge i_clock);
    step <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask : step_cmd
  task automatic hard_rst;
    i_hard_reset <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_hard_reset <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask : hard_rst
  // ********
  // Sequence
  // ********
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
  begin
    cycles++;
    // Sticky: the timeout pulses last one cycle, so catch any of them
    if (o_cmd_abort || o_cmd_uncorrectable)
      fault_seen = 1'b1;
    if (cycles == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial
  begin
    {i_rstn, i_hard_reset, i_setf_wcache, step, wr_sel, log_sel, i_awvalid, i_wvalid} = 8'h00;
    {i_bready, i_arvalid, i_rready, kind_sel, i_awaddr, i_araddr, i_wdata} = '0;
    i_wstrb = 4'hf;
    seed = 32'he633ebd4;
    bad = '{'{16'h3, 16'h5, 16'h1, 16'h64, 16'h0}, '{16'h3, 16'h1, 16'h3, 16'h64, 16'h0},
            '{16'h4, 16'h4, 16'h1, 16'h2, 16'h0}, '{16'h4, 16'h1, 16'h4, 16'h2, 16'h0}};
    repeat (12) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    rdm(`RFC_A_LIMITS, 32'hffffffff, 32'h0);
    rdm(`RFC_A_FEAT, 32'h0000ffff, 32'h1);
    wr(`RFC_A_TFOUT, 32'h1, 2'b10);
    rd(12'h030, d);
    chk(d, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    seed = lfsr(seed);
    lim = (seed[15:0] < 16'h0041) ? seed[15:0] + 16'h0041 : seed[15:0];
    key('{16'h3, 16'h1, 16'h1, lim, 16'h0}, tf_ok(16'h0), 1'b0);
    key('{16'h3, 16'h1, 16'h2, 16'h41, 16'h0}, tf_ok(16'h0), 1'b0);
    key('{16'h3, 16'h1, 16'h2, 16'h40, 16'h0}, 32'h51040000, 1'b1);
    key('{16'h3, 16'h2, 16'h1, 16'h0, 16'h0}, tf_ok(lim), 1'b1);
    key('{16'h3, 16'h2, 16'h2, 16'h0, 16'h0}, tf_ok(16'h41), 1'b1);
    for (int b = 0; b < 4; b++)
      key(bad[b], 32'h51040000, 1'b1);
    rdm(`RFC_A_LIMITS, 32'hffffffff, {16'h0041, lim});
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      kind_sel <= 2'(k);
      wr_sel <= seed[1];
      log_sel <= seed[2];
      step_cmd();
      rdm(`RFC_A_FEAT, 32'h30000, {14'h0, k == 0, (k == 0) & seed[1], 16'h0});
      step_cmd();
      rdm(`RFC_A_FEAT, 32'h30000, {14'h0, k < 2, (k < 2) & seed[1], 16'h0});
      step_cmd();
      rdm(`RFC_A_FEAT, 32'h30000, 32'h0);
    end
    rdm(`RFC_A_ESC, 32'hffffffff, 32'h0);
    for (int f = 1; f < 4; f++)
    begin
      seed = lfsr(seed);
      lim = (f == 1) ? 16'h2 : (f == 2) ? 16'h1 : (seed[15:0] | 16'h1);
      key('{16'h4, 16'h1, 16'(f), lim, 16'h0}, tf_ok(16'h0), 1'b0);
      key('{16'h4, 16'h2, 16'(f), 16'h0, 16'h0}, tf_ok(lim), 1'b1);
      key('{16'h4, 16'h3, 16'(f), 16'h0, 16'h0}, tf_ok(16'h0), 1'b1);
    end
    for (int s = 1; s < 4; s++)
    begin
      seed = lfsr(seed);
      i_setf_wcache <= seed[0];
      key('{16'h4, 16'h1, 16'h1, 16'(s), 16'h0}, tf_ok(16'h0), 1'b0);
      chk({31'h0, o_wcache_enable}, {31'h0, (s == 1) ? seed[0] : (s == 2)});
    end
    hard_rst();
    rdm(`RFC_A_FEAT, 32'h0000ffff, 32'h1);
    rdm(`RFC_A_LIMITS, 32'hffffffff, 32'h0);
    kind_sel <= 2'd0;
    step_cmd();
    rdm(`RFC_A_FEAT, 32'h20000, 32'h0);
    step_cmd();
    step_cmd();
    key('{16'h4, 16'h1, 16'h1, 16'h3, 16'h1}, tf_ok(16'h0), 1'b0);
    key('{16'h4, 16'h3, 16'h1, 16'h0, 16'h0}, tf_ok(16'h1), 1'b1);
    rdm(`RFC_A_NVFEAT, 32'h0000ffff, 32'h3);
    hard_rst();
    rdm(`RFC_A_FEAT, 32'h0000ffff, 32'h3);
    wr(`RFC_A_PRESET, 32'h1, 2'b00);
    hard_rst();
    rdm(`RFC_A_FEAT, 32'h0000ffff, 32'h1);
    chk({31'h0, fault_seen}, 32'h0);
    report_and_stop();
  end
endmodule : test_sct_recovery_feature_cmds
`default_nettype wire
